//--- verilog/sccal_top.sv
// Synced clock calendar with front-key setting and event stamping
//
// What this block does
// - Cascaded year-to-hundredths calendar counters.
// - Serial sync, period 5/10/15/30/60 minutes.
// - Sync off ignores every sync pulse.
// - Sync loads nearest expected instant, may round up.
// - Exactly halfway rounds down.
// - Menu entry shows date, one group blinking.
// - Down key cycles year, month, day.
// - Up key changes blinking group value.
// - Enter commits shown date.
// - Select shows time, edited the same way.
// - Sync on and change: halt until sync.
// - Sync off: clock never halts.
// - Commit clears tenths and hundredths.
// - Finest unit every 10ms; events stamped.
// - Fractions only on serial-side outputs.
`timescale 1ns/1ps

module sccal_top #(
  parameter int unsigned TICK_CYCLES = sccal_pkg::TICK_CYCLES
) (
  // Clock and reset
  input  wire logic                CLOCK,
  input  wire logic                RST_B,
  // Synchronisation
  input  wire sccal_pkg::sccal_sync_t SYNC_SEL,
  input  wire logic                SYNC_PULSE,
  // Front keys, one-cycle pulses
  input  wire logic                KEY_MENU,
  input  wire logic                KEY_EXIT,
  input  wire logic                KEY_DOWN,
  input  wire logic                KEY_UP,
  input  wire logic                KEY_ENTER,
  input  wire logic                KEY_SELECT,
  // Event stamping
  input  wire logic                EVENT,
  output sccal_pkg::sccal_time_t   STAMP,
  output logic                     STAMP_VALID,
  // Serial-side time
  output sccal_pkg::sccal_time_t   TIME_NOW,
  output logic                     TICK,
  output logic                     HALTED,
  // Local display
  output sccal_pkg::sccal_disp_t   DISP_TIME,
  output sccal_pkg::sccal_mode_t   DISP_MODE,
  output logic [1:0]               BLINK_GROUP
);
  import sccal_pkg::*;

  if (TICK_CYCLES < 2 || TICK_CYCLES >= (1 << TICK_CNT_W)) begin : g_bad_tick
    $error("TICK_CYCLES out of range");
  end

  localparam logic [TICK_CNT_W-1:0] DIV_LAST = TICK_CNT_W'(TICK_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Calendar arithmetic
  function automatic logic [4:0] days_in(input logic [3:0] m, input logic [6:0] y);
    case (m)
      FEBRUARY:                days_in = (y[1:0] == 2'h0) ? 5'h1D : 5'h1C;
      4'h4, 4'h6, 4'h9, 4'hB:  days_in = 5'h1E;
      default:                 days_in = 5'h1F;
    endcase
  endfunction : days_in

  function automatic sccal_time_t day_up(input sccal_time_t t);
    day_up = t;
    if (t.day >= days_in(t.month, t.year)) begin
      day_up.day = 5'h01;
      if (t.month == MONTH_LAST) begin
        day_up.month = 4'h1;
        day_up.year  = (t.year == YEAR_LAST) ? 7'h00 : t.year + 7'h01;
      end else begin
        day_up.month = t.month + 4'h1;
      end
    end else begin
      day_up.day = t.day + 5'h01;
    end
  endfunction : day_up

  function automatic sccal_time_t hour_up(input sccal_time_t t);
    hour_up = t;
    if (t.hour == HOUR_LAST) begin
      hour_up.hour = 5'h00;
      hour_up      = day_up(hour_up);
    end else begin
      hour_up.hour = t.hour + 5'h01;
    end
  endfunction : hour_up

  function automatic sccal_time_t cs_up(input sccal_time_t t);
    cs_up = t;
    if (t.hund != FRAC_LAST) begin
      cs_up.hund = t.hund + 4'h1;
    end else begin
      cs_up.hund = 4'h0;
      if (t.tenth != FRAC_LAST) begin
        cs_up.tenth = t.tenth + 4'h1;
      end else begin
        cs_up.tenth = 4'h0;
        if (t.second != SEC_LAST) begin
          cs_up.second = t.second + 6'h01;
        end else begin
          cs_up.second = 6'h00;
          if (t.minute != MIN_LAST) begin
            cs_up.minute = t.minute + 6'h01;
          end else begin
            cs_up.minute = 6'h00;
            cs_up        = hour_up(cs_up);
          end
        end
      end
    end
  endfunction : cs_up

  function automatic logic [5:0] period_min(input sccal_sync_t s);
    case (s)
      SYNC_5M:  period_min = 6'h05;
      SYNC_10M: period_min = 6'h0A;
      SYNC_15M: period_min = 6'h0F;
      SYNC_30M: period_min = 6'h1E;
      SYNC_60M: period_min = 6'h3C;
      default:  period_min = 6'h00;
    endcase
  endfunction : period_min

  // Snap to the nearest expected instant
  function automatic sccal_time_t sync_round(input sccal_time_t t, input logic [5:0] per);
    logic [5:0]  r;
    logic [18:0] off_cs;
    logic [18:0] half_cs;
    logic [6:0]  up_min;
    r          = (per == 6'h00) ? 6'h00 : t.minute % per;
    off_cs     = {13'h0000, r} * 19'h01770 + {13'h0000, t.second} * 19'h00064
               + {15'h0000, t.tenth} * 19'h0000A + {15'h0000, t.hund};
    half_cs    = {13'h0000, per} * 19'h00BB8;
    up_min     = {1'b0, t.minute - r} + {1'b0, per};
    sync_round = t;
    sync_round.second = 6'h00;
    sync_round.tenth  = 4'h0;
    sync_round.hund   = 4'h0;
    if (off_cs > half_cs) begin
      if (up_min > {1'b0, MIN_LAST}) begin
        sync_round.minute = 6'h00;
        sync_round        = hour_up(sync_round);
      end else begin
        sync_round.minute = up_min[5:0];
      end
    end else begin
      sync_round.minute = t.minute - r;
    end
  endfunction : sync_round

  // Cyclic step of one edited group
  function automatic sccal_time_t grp_up(input sccal_time_t t, input logic is_time,
                                         input logic [1:0] g);
    grp_up = t;
    if (!is_time) begin
      case (g)
        2'h0:    grp_up.year  = (t.year == YEAR_LAST) ? 7'h00 : t.year + 7'h01;
        2'h1:    grp_up.month = (t.month == MONTH_LAST) ? 4'h1 : t.month + 4'h1;
        default: grp_up.day   = (t.day >= days_in(t.month, t.year)) ? 5'h01 : t.day + 5'h01;
      endcase
    end else begin
      case (g)
        2'h0:    grp_up.hour   = (t.hour == HOUR_LAST) ? 5'h00 : t.hour + 5'h01;
        2'h1:    grp_up.minute = (t.minute == MIN_LAST) ? 6'h00 : t.minute + 6'h01;
        default: grp_up.second = (t.second == SEC_LAST) ? 6'h00 : t.second + 6'h01;
      endcase
    end
  endfunction : grp_up

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic [TICK_CNT_W-1:0] div_reg,   div_next;
  sccal_time_t           time_reg,  time_next;
  sccal_time_t           shad_reg,  shad_next;
  sccal_time_t           stamp_reg, stamp_next;
  sccal_disp_t           disp_reg,  disp_next;
  sccal_mode_t           mode_reg,  mode_next;
  logic [1:0]            grp_reg,   grp_next;
  logic                  halt_reg,  halt_next;
  logic                  tick_reg,  tick_next;
  logic                  sv_reg,    sv_next;
  logic                  sync_on;
  logic                  sync_hit;
  logic                  commit;
  logic [4:0]            dmax;

  always_comb begin
    sync_on    = (period_min(SYNC_SEL) != 6'h00);
    sync_hit   = SYNC_PULSE && sync_on;
    commit     = 1'b0;
    dmax       = days_in(shad_reg.month, shad_reg.year);
    div_next   = div_reg + 1'b1;
    tick_next  = 1'b0;
    time_next  = time_reg;
    shad_next  = shad_reg;
    mode_next  = mode_reg;
    grp_next   = grp_reg;
    halt_next  = halt_reg;
    stamp_next = stamp_reg;
    sv_next    = 1'b0;
    if (div_reg == DIV_LAST) begin
      div_next  = '0;
      tick_next = 1'b1;
    end

    // Key handling
    case (mode_reg)
      MODE_IDLE: begin
        if (KEY_MENU) begin
          mode_next = MODE_DATE;
          shad_next = time_reg;
          grp_next  = GRP_FIRST;
        end
      end
      MODE_DATE, MODE_TIME: begin
        if (KEY_EXIT) begin
          mode_next = MODE_IDLE;
        end else if (KEY_ENTER) begin
          commit    = 1'b1;
          mode_next = MODE_IDLE;
          time_next = time_reg;
          if (mode_reg == MODE_DATE) begin
            time_next.year  = shad_reg.year;
            time_next.month = shad_reg.month;
            time_next.day   = (shad_reg.day > dmax) ? dmax : shad_reg.day;
          end else begin
            time_next.hour   = shad_reg.hour;
            time_next.minute = shad_reg.minute;
            time_next.second = shad_reg.second;
          end
          time_next.tenth = 4'h0;
          time_next.hund  = 4'h0;
        end else if (KEY_SELECT) begin
          mode_next = (mode_reg == MODE_DATE) ? MODE_TIME : MODE_DATE;
          shad_next = time_reg;
          grp_next  = GRP_FIRST;
        end else if (KEY_DOWN) begin
          grp_next = (grp_reg == GRP_LAST) ? GRP_FIRST : grp_reg + 2'h1;
        end else if (KEY_UP) begin
          shad_next = grp_up(shad_reg, mode_reg == MODE_TIME, grp_reg);
        end
      end
      default: mode_next = MODE_IDLE;
    endcase

    // Time keeping: commit, then sync, then tick
    if (commit) begin
      div_next  = '0;
      halt_next = sync_on;
    end else if (sync_hit) begin
      time_next = sync_round(time_reg, period_min(SYNC_SEL));
      div_next  = '0;
      halt_next = 1'b0;
    end else if (tick_next && !halt_reg) begin
      time_next = cs_up(time_reg);
    end
    if (!sync_on) begin
      halt_next = 1'b0;
    end

    if (EVENT) begin
      stamp_next = time_reg;
      sv_next    = 1'b1;
    end

    // Display carries no fractions
    if (mode_next == MODE_IDLE) begin
      disp_next = '{time_next.year, time_next.month, time_next.day,
                    time_next.hour, time_next.minute, time_next.second};
    end else begin
      disp_next = '{shad_next.year, shad_next.month, shad_next.day,
                    shad_next.hour, shad_next.minute, shad_next.second};
    end
  end

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      div_reg   <= '0;
      time_reg  <= TIME_RST;
      shad_reg  <= TIME_RST;
      stamp_reg <= TIME_RST;
      disp_reg  <= '{TIME_RST.year, TIME_RST.month, TIME_RST.day,
                     TIME_RST.hour, TIME_RST.minute, TIME_RST.second};
      mode_reg  <= MODE_IDLE;
      grp_reg   <= GRP_FIRST;
      halt_reg  <= 1'b0;
      tick_reg  <= 1'b0;
      sv_reg    <= 1'b0;
    end else begin
      div_reg   <= div_next;
      time_reg  <= time_next;
      shad_reg  <= shad_next;
      stamp_reg <= stamp_next;
      disp_reg  <= disp_next;
      mode_reg  <= mode_next;
      grp_reg   <= grp_next;
      halt_reg  <= halt_next;
      tick_reg  <= tick_next;
      sv_reg    <= sv_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign TIME_NOW    = time_reg;
  assign STAMP       = stamp_reg;
  assign STAMP_VALID = sv_reg;
  assign TICK        = tick_reg;
  assign HALTED      = halt_reg;
  assign DISP_TIME   = disp_reg;
  assign DISP_MODE   = mode_reg;
  assign BLINK_GROUP = grp_reg;

endmodule : sccal_top

//--- verilog/sccal_pkg.sv
// Constants and types for the synced clock calendar
package sccal_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int unsigned CLK_HZ         = 50_000_000;
  localparam int unsigned TICK_MS        = 10;
  localparam int unsigned TICK_CYCLES    = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned TICK_CNT_W     = 20;

  ////////////////////////////////////////////////////////////////////////////
  // Calendar limits
  localparam logic [6:0] YEAR_LAST      = 7'h63;
  localparam logic [3:0] MONTH_LAST     = 4'hC;
  localparam logic [4:0] HOUR_LAST      = 5'h17;
  localparam logic [5:0] MIN_LAST       = 6'h3B;
  localparam logic [5:0] SEC_LAST       = 6'h3B;
  localparam logic [3:0] FRAC_LAST      = 4'h9;
  localparam logic [3:0] FEBRUARY       = 4'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [2:0] {
    SYNC_OFF,
    SYNC_5M,
    SYNC_10M,
    SYNC_15M,
    SYNC_30M,
    SYNC_60M
  } sccal_sync_t;

  typedef enum logic [1:0] {
    MODE_IDLE,
    MODE_DATE,
    MODE_TIME
  } sccal_mode_t;

  typedef struct packed {
    logic [6:0] year;
    logic [3:0] month;
    logic [4:0] day;
    logic [4:0] hour;
    logic [5:0] minute;
    logic [5:0] second;
    logic [3:0] tenth;
    logic [3:0] hund;
  } sccal_time_t;

  typedef struct packed {
    logic [6:0] year;
    logic [3:0] month;
    logic [4:0] day;
    logic [4:0] hour;
    logic [5:0] minute;
    logic [5:0] second;
  } sccal_disp_t;

  // Group index: 0 year/hour, 1 month/minute, 2 day/second
  localparam logic [1:0] GRP_FIRST      = 2'h0;
  localparam logic [1:0] GRP_LAST       = 2'h2;

  localparam sccal_time_t TIME_RST = '{year: 7'h00, month: 4'h1, day: 5'h01,
                                       hour: 5'h00, minute: 6'h00, second: 6'h00,
                                       tenth: 4'h0, hund: 4'h0};

endpackage : sccal_pkg

//--- tb/sccal_asserts.sv
// Concurrent checks on the calendar top-level ports
`timescale 1ns/1ps

module sccal_asserts
  import sccal_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = sccal_pkg::TICK_CYCLES
) (
  // Clock and reset
  input wire logic                   CLOCK,
  input wire logic                   RST_B,
  // Synchronisation
  input wire sccal_pkg::sccal_sync_t SYNC_SEL,
  input wire logic                   SYNC_PULSE,
  // Front keys
  input wire logic                   KEY_MENU,
  input wire logic                   KEY_EXIT,
  input wire logic                   KEY_DOWN,
  input wire logic                   KEY_UP,
  input wire logic                   KEY_ENTER,
  input wire logic                   KEY_SELECT,
  // Stamping and time
  input wire logic                   EVENT,
  input wire sccal_pkg::sccal_time_t STAMP,
  input wire logic                   STAMP_VALID,
  input wire sccal_pkg::sccal_time_t TIME_NOW,
  input wire logic                   TICK,
  input wire logic                   HALTED,
  // Display
  input wire sccal_pkg::sccal_disp_t DISP_TIME,
  input wire sccal_pkg::sccal_mode_t DISP_MODE,
  input wire logic [1:0]             BLINK_GROUP
);
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RST_B);

  wire logic   sync_on = SYNC_SEL inside {[SYNC_5M:SYNC_60M]};
  wire logic   menu    = DISP_MODE != MODE_IDLE;
  logic [19:0] gap_reg;
  logic [19:0] gap_next;

  function automatic int pmin(input logic [2:0] s);
    case (s)
      3'h1: return 5;
      3'h2: return 10;
      3'h3: return 15;
      3'h4: return 30;
      default: return 60;
    endcase
  endfunction : pmin

  // Cycles since the last tick
  always_comb gap_next = TICK ? 20'h00000 : gap_reg + 20'h00001;
  always_ff @(posedge CLOCK or negedge RST_B)
    if (!RST_B) gap_reg <= 20'h00000;
    else gap_reg <= gap_next;

  ////////////////////////////////////////////////////////////////////////////
  a_event_stamp:
    assert property (EVENT |=> STAMP_VALID && STAMP == $past(TIME_NOW))
    else $error("stamp not taken from event time");
  a_stamp_pulse:
    assert property (!EVENT |=> !STAMP_VALID)
    else $error("stamp valid without event");
  a_tick_gap:
    assert property (TICK |-> gap_reg >= 20'(TICK_CYCLES - 1))
    else $error("ticks too close");
  a_menu_entry:
    assert property (!menu && KEY_MENU |=> DISP_MODE == MODE_DATE && BLINK_GROUP == GRP_FIRST)
    else $error("menu entry wrong");
  a_cursor_cycle:
    assert property (menu && KEY_DOWN && !KEY_EXIT && !KEY_ENTER && !KEY_SELECT |=>
      BLINK_GROUP == ($past(BLINK_GROUP) == GRP_LAST ? GRP_FIRST : $past(BLINK_GROUP) + 2'h1))
    else $error("cursor did not advance");
  a_select_time:
    assert property (DISP_MODE == MODE_DATE && KEY_SELECT && !KEY_EXIT && !KEY_ENTER |=>
      DISP_MODE == MODE_TIME && BLINK_GROUP == GRP_FIRST)
    else $error("select did not show time");
  a_commit_idle:
    assert property (menu && KEY_ENTER && !KEY_EXIT |=> !menu && TIME_NOW.tenth == 4'h0 &&
      TIME_NOW.hund == 4'h0 && HALTED == $past(sync_on))
    else $error("commit result wrong");
  a_halt_hold:
    assert property (HALTED && sync_on && !SYNC_PULSE && !menu |=> HALTED && $stable(TIME_NOW))
    else $error("halted clock moved");
  a_sync_off:
    assert property (!sync_on && !menu |=> !HALTED && (TICK || $stable(TIME_NOW)))
    else $error("time moved without tick");
  a_sync_round:
    assert property (sync_on && SYNC_PULSE && !menu |=> !HALTED && TIME_NOW.second == 6'h00 &&
      TIME_NOW.tenth == 4'h0 && TIME_NOW.hund == 4'h0 &&
      TIME_NOW.minute % pmin($past(SYNC_SEL)) == 0)
    else $error("sync did not round");
endmodule : sccal_asserts

bind sccal_top sccal_asserts #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
  .CLOCK(CLOCK), .RST_B(RST_B), .SYNC_SEL(SYNC_SEL), .SYNC_PULSE(SYNC_PULSE),
  .KEY_MENU(KEY_MENU), .KEY_EXIT(KEY_EXIT), .KEY_DOWN(KEY_DOWN), .KEY_UP(KEY_UP),
  .KEY_ENTER(KEY_ENTER), .KEY_SELECT(KEY_SELECT), .EVENT(EVENT), .STAMP(STAMP),
  .STAMP_VALID(STAMP_VALID), .TIME_NOW(TIME_NOW), .TICK(TICK), .HALTED(HALTED),
  .DISP_TIME(DISP_TIME), .DISP_MODE(DISP_MODE), .BLINK_GROUP(BLINK_GROUP));

//--- tb/sccal_host.sv
// Serial host model issuing broadcast sync pulses
`timescale 1ns/1ps

module sccal_host (
  // Clock
  input wire logic clk,
  // Sync line
  output logic     sync_pulse
);
  initial sync_pulse = 1'b0;

  // One broadcast after a chosen delay
  task automatic send(input int wait_cyc);
    repeat (wait_cyc + 1) @(negedge clk);
    sync_pulse = 1'b1;
    @(negedge clk);
    sync_pulse = 1'b0;
  endtask : send
endmodule : sccal_host

//--- tb/tb_top.sv
// Self-checking bench for the synced clock calendar
`timescale 1ns/1ps

module tb_top;
  import sccal_pkg::*;
  localparam int unsigned TCK = 10;
  logic        clock, rst_b, ev, sync_pulse, stamp_valid, tick, halted;
  logic [5:0]  key;
  logic [1:0]  grp;
  logic [31:0] lfsr;
  sccal_sync_t sel;
  sccal_time_t stamp, now, exp_t;
  sccal_disp_t disp;
  sccal_mode_t mode;
  int          mismatches, samples_checked, s_m, s_s, n, gap;
  sccal_sync_t cs[7] = '{SYNC_10M, SYNC_10M, SYNC_10M, SYNC_5M, SYNC_15M, SYNC_30M, SYNC_60M};
  int          cm[7] = '{3, 6, 5, 12, 22, 44, 30};
  int          cc[7] = '{10, 34, 0, 31, 30, 59, 1};
  int          per[6] = '{0, 5, 10, 15, 30, 60};

  sccal_top #(.TICK_CYCLES(TCK)) DUT (
    .CLOCK(clock), .RST_B(rst_b), .SYNC_SEL(sel), .SYNC_PULSE(sync_pulse),
    .KEY_MENU(key[0]), .KEY_EXIT(key[1]), .KEY_DOWN(key[2]), .KEY_UP(key[3]),
    .KEY_ENTER(key[4]), .KEY_SELECT(key[5]), .EVENT(ev), .STAMP(stamp),
    .STAMP_VALID(stamp_valid), .TIME_NOW(now), .TICK(tick), .HALTED(halted),
    .DISP_TIME(disp), .DISP_MODE(mode), .BLINK_GROUP(grp));
  sccal_host host (.clk(clock), .sync_pulse(sync_pulse));

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] next_rand(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : next_rand

  // Nearest sync instant, halfway rounds down
  function automatic sccal_time_t rounded(input sccal_time_t t, input int p);
    int off;
    off = (t.minute % p) * 60 + t.second;
    t.minute = 6'(t.minute - t.minute % p);
    if (off * 2 > p * 60) t.minute = 6'(t.minute + p);
    if (t.minute == 6'h3C) begin
      t.minute = 6'h00;
      t.hour = t.hour + 5'h01;
    end
    t.second = 6'h00;
    t.tenth = 4'h0;
    t.hund = 4'h0;
    return t;
  endfunction : rounded

  task automatic check(input logic [47:0] seen, input logic [47:0] want);
    samples_checked++;
    if (seen !== want) begin
      mismatches++;
      $display("[FAIL] %0t seen %h want %h", $time, seen, want);
    end
  endtask : check

  task automatic press(input int k, input int cnt);
    repeat (cnt) begin
      key[k] = 1'b1;
      @(negedge clock);
      key[k] = 1'b0;
      @(negedge clock);
    end
  endtask : press

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : tally_and_finish

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (30000) @(posedge clock);
    mismatches++;
    tally_and_finish();
  end

  initial begin
    rst_b = 1'b0;
    sel = SYNC_30M;
    key = 6'h00;
    ev = 1'b0;
    lfsr = next_rand(32'hE4E2);
    repeat (12) @(negedge clock);
    rst_b = 1'b1;
    check(48'(now), 48'(TIME_RST));
    // Random date edit with sync on
    press(0, 1);
    check(48'(mode), 48'(MODE_DATE));
    press(3, lfsr[3:0]);
    check(48'(disp.year), 48'(lfsr[3:0]));
    press(2, 1);
    press(3, lfsr[6:4]);
    press(2, 1);
    press(3, lfsr[10:8]);
    press(2, 1);
    check(48'(grp), 48'(GRP_FIRST));
    press(4, 1);
    exp_t = TIME_RST;
    exp_t.year = 7'(lfsr[3:0]);
    exp_t.month = 4'h1 + 4'(lfsr[6:4]);
    exp_t.day = 5'h01 + 5'(lfsr[10:8]);
    check(48'(now), 48'(exp_t));
    check(48'(halted), 48'h1);
    repeat (3 * TCK) @(negedge clock);
    check(48'(now), 48'(exp_t));
    host.send(5);
    check(48'(halted), 48'h0);
    // Rounding table, then random cases
    for (int i = 0; i < 10; i++) begin
      lfsr = next_rand(lfsr);
      s_m = i < 7 ? cm[i] : int'(lfsr[5:0]) % 60;
      s_s = i < 7 ? cc[i] : int'(lfsr[13:8]) % 60;
      sel = i < 7 ? cs[i] : sccal_sync_t'(int'(lfsr[18:16]) % 5 + 1);
      press(0, 1);
      press(5, 1);
      press(2, 1);
      press(3, (s_m - int'(exp_t.minute) + 60) % 60);
      press(2, 1);
      press(3, s_s);
      exp_t.minute = 6'(s_m);
      exp_t.second = 6'(s_s);
      press(4, 1);
      check(48'(now), 48'(exp_t));
      check(48'(halted), 48'h1);
      host.send(i % 3);
      exp_t = rounded(exp_t, per[sel]);
      check(48'(now), 48'(exp_t));
    end
    // Select toggles back to date, then leave without commit
    press(0, 1);
    press(5, 2);
    check(48'(mode), 48'(MODE_DATE));
    press(3, 2);
    press(1, 1);
    check(48'(mode), 48'(MODE_IDLE));
    check(48'(now.year), 48'(exp_t.year));
    // Midnight carry with sync off
    sel = SYNC_OFF;
    press(0, 1);
    press(5, 1);
    press(3, 23 - int'(exp_t.hour));
    press(2, 1);
    press(3, 59 - int'(exp_t.minute));
    press(2, 1);
    press(3, 59);
    press(4, 1);
    check(48'(halted), 48'h0);
    host.send(0);
    n = 0;
    gap = 0;
    while (n < 100) begin
      @(negedge clock);
      gap++;
      if (tick === 1'b1) begin
        if (n > 0) check(48'(gap), 48'(TCK));
        n++;
        gap = 0;
      end
    end
    exp_t.day = exp_t.day + 5'h01;
    exp_t.hour = 5'h00;
    exp_t.minute = 6'h00;
    exp_t.second = 6'h00;
    check(48'(now), 48'(exp_t));
    check(48'(disp), 48'(exp_t[40:8]));
    ev = 1'b1;
    exp_t = now;
    @(negedge clock);
    ev = 1'b0;
    check(48'(stamp_valid), 48'h1);
    check(48'(stamp), 48'(exp_t));
    tally_and_finish();
  end
endmodule : tb_top
